/* File: core/mmsc_mode_switch.sv */
// Purpose: Real/virtual mode switch checker with phase compensation.
// Assumes: Status pins are asynchronous; speed and command come on clock.
// Notes:   Global checks run before the per-axis scan, one axis a cycle.
// Operation
// - Request on selects virtual, off selects real.
// - Mode state flag shows virtual mode.
// - Rising request runs all checks first.
// - Failing check sets error flag and code.
// - Needs controller and processor ready.
// - Needs all start-accept flags off.
// - Needs program, matching axes, unaltered cams.
// - Needs all-axes servo-on command.
// - Fails during servo error-reset start.
// - Fails on encoder fault or forced stop.
// - Fails on servo error, or home request on output-module axes.
// - Output-module axes need matching units.
// - Cam axes need registered cam number.
// - Cam stroke positive, location even.
// - Bad time constant: error, no smoothing.
// - Time constant latched on enable rise.
// - Speed times advance added to command.
// - Falling request needs stopped axes.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module mmsc_mode_switch #(
  parameter int OP_CLKS = mmsc_pkg::OP_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [mmsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Status pins
  input  wire mmsc_pkg::mmsc_pins_t       statusPins,
  // Servo command path
  input  wire logic [31:0]                commandSpeed,
  input  wire logic [31:0]                servoCmdIn,
  output logic [31:0]                     servoCmdOut,
  // Mode flags
  output logic                            modeStateFlag,
  output logic                            modeSwitchErrorFlag
);
  import mmsc_pkg::*;

  mmsc_pins_t  pinMeta_q, pins_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] usedMask_q, rollerMask_q, realMask_q, camMask_q;
  logic [31:0] unitOk_q, camOk_q, locEven_q;
  logic [31:0] strokeMem [AXES];
  logic [31:0] pcAdv_q, pcTc_q, tcLatch_q, comp_q, prdata_q, servoCmd_q, info1_q, info2_q;
  logic        pcEnable_q, pcEnablePrev_q, minorErr_q;
  logic        mode_q, err_q, reqSeen_q;
  logic [7:0]  info0_q;
  logic [4:0]  axisIdx_q;
  logic [16:0] opCnt_q;
  mmsc_state_t state_q, state_d;

  // Two-stage synchroniser for every asynchronous status pin.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= '0;
      pins_q    <= '0;
    end else begin
      pinMeta_q <= statusPins;
      pins_q    <= pinMeta_q;
    end
  end

  // APB decode; read data is captured in the setup cycle, so one wait-free access.
  wire         setupPh  = psel & ~penable;
  wire         wrAcc    = psel & penable & pwrite;
  wire [11:0]  addr     = {paddr[11:2], 2'b00};
  wire         isStroke = (addr >= OFS_STROKE) && (addr <= STROKE_END);
  wire [4:0]   strokeIx = addr[6:2];

  function automatic logic isMapped(input logic [11:0] a);
    case (a)
      OFS_CTRL, OFS_STATUS, OFS_ERRINFO0, OFS_ERRINFO1, OFS_ERRINFO2, OFS_USED,
      OFS_ROLLER, OFS_REALAX, OFS_CAM, OFS_UNITOK, OFS_CAMOK, OFS_LOCEVEN,
      OFS_PC_ADV, OFS_PC_TC, OFS_PC_CTRL, OFS_PC_MON, OFS_MINOR: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  wire         mapped = isMapped(addr) | isStroke;
  wire         wrOk   = wrAcc & mapped;
  wire [31:0]  statusWord = {29'h0, state_q != MMSC_IDLE, err_q, mode_q};
  logic [31:0] rdMux;
  always_comb begin
    case (addr)
      OFS_CTRL:     rdMux = {26'h0, ctrl_q};
      OFS_STATUS:   rdMux = statusWord;
      OFS_ERRINFO0: rdMux = {24'h0, info0_q};
      OFS_ERRINFO1: rdMux = info1_q;
      OFS_ERRINFO2: rdMux = info2_q;
      OFS_USED:     rdMux = usedMask_q;
      OFS_ROLLER:   rdMux = rollerMask_q;
      OFS_REALAX:   rdMux = realMask_q;
      OFS_CAM:      rdMux = camMask_q;
      OFS_UNITOK:   rdMux = unitOk_q;
      OFS_CAMOK:    rdMux = camOk_q;
      OFS_LOCEVEN:  rdMux = locEven_q;
      OFS_PC_ADV:   rdMux = pcAdv_q;
      OFS_PC_TC:    rdMux = pcTc_q;
      OFS_PC_CTRL:  rdMux = {31'h0, pcEnable_q};
      OFS_PC_MON:   rdMux = comp_q;
      OFS_MINOR:    rdMux = minorErr_q ? {16'h0, MINOR_TC} : 32'h0;
      default:      rdMux = isStroke ? strokeMem[strokeIx] : 32'h0;
    endcase
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
    end else if (setupPh && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  // Software-written configuration.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q       <= '0;
      usedMask_q   <= 32'h0;
      rollerMask_q <= 32'h0;
      realMask_q   <= 32'h0;
      camMask_q    <= 32'h0;
      unitOk_q     <= 32'h0;
      camOk_q      <= 32'h0;
      locEven_q    <= 32'h0;
      pcAdv_q      <= 32'h0;
      pcTc_q       <= 32'h0;
      pcEnable_q   <= 1'b0;
    end else if (wrOk) begin
      case (addr)
        OFS_CTRL:    ctrl_q       <= pwdata[CTRL_W-1:0];
        OFS_USED:    usedMask_q   <= pwdata;
        OFS_ROLLER:  rollerMask_q <= pwdata;
        OFS_REALAX:  realMask_q   <= pwdata;
        OFS_CAM:     camMask_q    <= pwdata;
        OFS_UNITOK:  unitOk_q     <= pwdata;
        OFS_CAMOK:   camOk_q      <= pwdata;
        OFS_LOCEVEN: locEven_q    <= pwdata;
        OFS_PC_ADV:  pcAdv_q      <= pwdata;
        OFS_PC_TC:   pcTc_q       <= pwdata;
        OFS_PC_CTRL: pcEnable_q   <= pwdata[0];
        default:     ;
      endcase
    end
  end

  // Stroke memory has no reset; software loads it before requesting virtual mode.
  always_ff @(posedge clock) begin
    if (wrOk && isStroke) begin
      strokeMem[strokeIx] <= pwdata;
    end
  end

  // Global checks in sequence order; the first failure names the code.
  logic [7:0] globCode;
  always_comb begin
    if (!ctrl_q[CB_CTRL_RDY] || !pins_q.processorReady)            globCode = EC_READY;
    else if (|pins_q.startAccept)                                  globCode = EC_MOVING;
    else if (ctrl_q[CB_CAM_ALTER] || !ctrl_q[CB_PROG_REG])         globCode = EC_PROGRAM;
    else if (!ctrl_q[CB_AXES_MATCH])                               globCode = EC_AXES;
    else if (!ctrl_q[CB_SERVO_ON])                                 globCode = EC_SERVO_ON;
    else if (pins_q.encoderFault)                                  globCode = EC_ENCODER;
    else if (pins_q.forcedStop)                                    globCode = EC_FSTOP;
    else                                                           globCode = EC_NONE;
  end

  // Per-axis checks for the axis under scan.
  wire [4:0]  ax        = axisIdx_q;
  wire        axUsed    = usedMask_q[ax];
  wire        axModule  = axUsed & ~rollerMask_q[ax] & ~realMask_q[ax];
  wire        axCam     = axModule & camMask_q[ax];
  wire [31:0] axStroke  = strokeMem[ax];
  wire        strokeBad = axStroke[31] | (axStroke == 32'h0);
  logic [7:0] axCode;
  always_comb begin
    if (axUsed && pins_q.servoResetBusy[ax])      axCode = EC_RST_BUSY;
    else if (axUsed && pins_q.servoError[ax])     axCode = EC_SERVO_ERR;
    else if (axModule && pins_q.homeReturnReq[ax]) axCode = EC_HOME;
    else if (axModule && !unitOk_q[ax])           axCode = EC_UNITS;
    else if (axCam && !camOk_q[ax])               axCode = EC_CAM_DATA;
    else if (axCam && strokeBad)                  axCode = EC_STROKE;
    else if (axCam && !locEven_q[ax])             axCode = EC_STROKE_LOC;
    else                                          axCode = EC_NONE;
  end

  wire reqNow  = ctrl_q[CB_REQ];
  wire reqRise = (state_q == MMSC_IDLE) & reqNow & ~reqSeen_q;
  wire reqFall = (state_q == MMSC_IDLE) & ~reqNow & reqSeen_q;
  wire realBad = |pins_q.startAccept;
  wire globFail = (state_q == MMSC_GLOB) & (globCode != EC_NONE);
  wire axFail   = (state_q == MMSC_SCAN) & (axCode != EC_NONE);
  wire failNow  = globFail | axFail | (reqFall & realBad);
  wire errClr   = wrOk & (addr == OFS_STATUS) & pwdata[SB_ERR];

  always_comb begin
    case (state_q)
      MMSC_IDLE: state_d = reqRise ? MMSC_GLOB : MMSC_IDLE;
      MMSC_GLOB: state_d = globFail ? MMSC_IDLE : MMSC_SCAN;
      MMSC_SCAN: state_d = axFail ? MMSC_IDLE : ((ax == 5'h1f) ? MMSC_DONE : MMSC_SCAN);
      MMSC_DONE: state_d = MMSC_IDLE;
      default:   state_d = MMSC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= MMSC_IDLE;
      axisIdx_q <= 5'h0;
      reqSeen_q <= 1'b0;
      mode_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      axisIdx_q <= (state_q == MMSC_SCAN) ? axisIdx_q + 5'h1 : 5'h0;
      if (reqRise || reqFall) begin
        reqSeen_q <= reqNow;
      end
      // Mode changes only on a clean pass; a failure leaves it alone.
      if (state_q == MMSC_DONE) begin
        mode_q <= 1'b1;
      end else if (reqFall && !realBad) begin
        mode_q <= 1'b0;
      end
    end
  end

  // Error flag: a new failure wins over a software clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      err_q   <= 1'b0;
      info0_q <= EC_NONE;
      info1_q <= 32'h0;
      info2_q <= 32'h0;
    end else begin
      if (failNow) begin
        err_q   <= 1'b1;
        info0_q <= globFail ? globCode : (axFail ? axCode : EC_VIRT_RUN);
        info1_q <= axFail ? {27'h0, ax} : 32'h0;
        info2_q <= reqFall ? pins_q.startAccept : {31'h0, 1'b1};
      end else if (errClr) begin
        err_q <= 1'b0;
      end
    end
  end

  assign modeStateFlag       = mode_q;
  assign modeSwitchErrorFlag = err_q;

  // Operation cycle enable pulse.
  wire opTick = (opCnt_q == 17'(OP_CLKS - 1));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      opCnt_q <= 17'h0;
    end else begin
      opCnt_q <= opTick ? 17'h0 : opCnt_q + 17'h1;
    end
  end

  // Compensation target is speed [PLS/s] times advance time [us].
  wire signed [63:0] prod   = $signed(commandSpeed) * $signed(pcAdv_q);
  wire signed [63:0] quot   = prod / $signed(US_PER_S);
  wire signed [31:0] goal   = pcEnable_q ? quot[31:0] : 32'sh0;
  wire signed [31:0] diff   = goal - $signed(comp_q);
  wire               tcBad  = (pcTc_q > TC_MAX);
  wire               enRise = pcEnable_q & ~pcEnablePrev_q;
  // On the enable edge the new constant already rules, so a tick there does not jump.
  wire        [31:0] tcNow  = enRise ? (tcBad ? 32'h0 : pcTc_q) : tcLatch_q;
  wire signed [31:0] stepV  = diff / $signed(tcNow);
  wire               minClr = wrOk & (addr == OFS_MINOR);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pcEnablePrev_q <= 1'b0;
      tcLatch_q      <= 32'h0;
      minorErr_q     <= 1'b0;
      comp_q         <= 32'h0;
      servoCmd_q     <= 32'h0;
    end else begin
      pcEnablePrev_q <= pcEnable_q;
      if (enRise) begin
        tcLatch_q <= tcBad ? 32'h0 : pcTc_q;
      end
      if (enRise && tcBad) begin
        minorErr_q <= 1'b1;
      end else if (minClr) begin
        minorErr_q <= 1'b0;
      end
      // A zero time constant jumps straight to the goal, without smoothing.
      if (opTick) begin
        comp_q <= (tcNow == 32'h0) ? goal : comp_q + stepV;
      end
      servoCmd_q <= servoCmdIn + comp_q;
    end
  end

  assign servoCmdOut = servoCmd_q;
endmodule
`default_nettype wire

/* File: core/mmsc_pkg.sv */
// Purpose: Shared constants and types of the motion mode switch checker.
// Assumes: APB register map with one 32-bit word per register.
// Notes:   Entry-check error codes are their check sequence numbers; EC_VIRT_RUN marks a failed exit.
package mmsc_pkg;
  localparam int          AXES          = 32;
  localparam int          ADDR_W        = 12;
  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_ERRINFO0  = 12'h008;
  localparam logic [11:0] OFS_ERRINFO1  = 12'h00c;
  localparam logic [11:0] OFS_ERRINFO2  = 12'h010;
  localparam logic [11:0] OFS_USED      = 12'h014;
  localparam logic [11:0] OFS_ROLLER    = 12'h018;
  localparam logic [11:0] OFS_REALAX    = 12'h01c;
  localparam logic [11:0] OFS_CAM       = 12'h020;
  localparam logic [11:0] OFS_UNITOK    = 12'h024;
  localparam logic [11:0] OFS_CAMOK     = 12'h028;
  localparam logic [11:0] OFS_LOCEVEN   = 12'h02c;
  localparam logic [11:0] OFS_PC_ADV    = 12'h040;
  localparam logic [11:0] OFS_PC_TC     = 12'h044;
  localparam logic [11:0] OFS_PC_CTRL   = 12'h048;
  localparam logic [11:0] OFS_PC_MON    = 12'h04c;
  localparam logic [11:0] OFS_MINOR     = 12'h050;
  localparam logic [11:0] OFS_STROKE    = 12'h080;
  localparam logic [11:0] STROKE_END    = 12'h0fc;
  // CTRL bit positions.
  localparam int          CB_REQ        = 0;
  localparam int          CB_SERVO_ON   = 1;
  localparam int          CB_CTRL_RDY   = 2;
  localparam int          CB_PROG_REG   = 3;
  localparam int          CB_AXES_MATCH = 4;
  localparam int          CB_CAM_ALTER  = 5;
  localparam int          CTRL_W        = 6;
  // STATUS bit positions.
  localparam int          SB_MODE       = 0;
  localparam int          SB_ERR        = 1;
  localparam int          SB_BUSY       = 2;
  // Error codes held in the first information word.
  localparam logic [7:0]  EC_NONE       = 8'h00;
  localparam logic [7:0]  EC_READY      = 8'h01;
  localparam logic [7:0]  EC_MOVING     = 8'h02;
  localparam logic [7:0]  EC_PROGRAM    = 8'h03;
  localparam logic [7:0]  EC_AXES       = 8'h04;
  localparam logic [7:0]  EC_SERVO_ON   = 8'h05;
  localparam logic [7:0]  EC_RST_BUSY   = 8'h06;
  localparam logic [7:0]  EC_ENCODER    = 8'h07;
  localparam logic [7:0]  EC_FSTOP      = 8'h08;
  localparam logic [7:0]  EC_SERVO_ERR  = 8'h09;
  localparam logic [7:0]  EC_HOME       = 8'h0a;
  localparam logic [7:0]  EC_UNITS      = 8'h0b;
  localparam logic [7:0]  EC_CAM_DATA   = 8'h0c;
  localparam logic [7:0]  EC_STROKE     = 8'h0e;
  localparam logic [7:0]  EC_STROKE_LOC = 8'h0f;
  localparam logic [7:0]  EC_VIRT_RUN   = 8'h10;
  // Phase compensation.
  localparam logic [15:0] MINOR_TC      = 16'h189c;
  localparam logic [31:0] TC_MAX        = 32'h00007fff;
  localparam logic [63:0] US_PER_S      = 64'h00000000000f4240;
  // Operation cycle timing.
  localparam int          CLK_NS        = 8;
  localparam int          OP_CYCLE_NS   = 880000;
  localparam int          OP_CYCLE_CLKS = OP_CYCLE_NS / CLK_NS;

  typedef enum logic [1:0] {
    MMSC_IDLE  = 2'b00,
    MMSC_GLOB  = 2'b01,
    MMSC_SCAN  = 2'b10,
    MMSC_DONE  = 2'b11
  } mmsc_state_t;

  // Asynchronous axis and system status pins.
  typedef struct packed {
    logic [31:0] servoResetBusy;
    logic [31:0] servoError;
    logic [31:0] homeReturnReq;
    logic [31:0] startAccept;
    logic        processorReady;
    logic        encoderFault;
    logic        forcedStop;
  } mmsc_pins_t;
endpackage

/* File: test/mmsc_mode_switch_sva.sv */
// Purpose: Port-level checks of the mode switch checker.
// Assumes: One clock domain; reset_n asynchronous, active low.
// Notes:   A shadow of CTRL writes lets mode changes be judged.
`timescale 1ns/100ps
`default_nettype none
module mmsc_mode_switch_sva #(
  parameter int OP_CLKS = mmsc_pkg::OP_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // APB
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mmsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr,
  // Status and servo path
  input  wire mmsc_pkg::mmsc_pins_t        statusPins,
  input  wire logic [31:0]                 commandSpeed,
  input  wire logic [31:0]                 servoCmdIn,
  input  wire logic [31:0]                 servoCmdOut,
  // Mode flags
  input  wire logic                        modeStateFlag,
  input  wire logic                        modeSwitchErrorFlag
);
  import mmsc_pkg::*;
  logic [5:0] ctrl_q;
  logic [7:0] sinceWr_q;
  logic       compOn_q;
  wire        wrAcc = psel && penable && pwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q    <= 6'h00;
      sinceWr_q <= 8'hff;
      compOn_q  <= 1'b0;
    end else begin
      if (wrAcc && paddr == OFS_CTRL) ctrl_q <= pwdata[5:0];
      sinceWr_q <= (wrAcc && paddr == OFS_CTRL) ? 8'h00 : sinceWr_q + {7'h0, sinceWr_q != 8'hff};
      if (wrAcc && paddr == OFS_PC_CTRL) compOn_q <= 1'b1;
    end
  end
  a_virt_ctrl_ok: assert property ($rose(modeStateFlag) |-> ctrl_q == 6'h1f)
    else $error("virtual mode entered with control checks failing");
  a_virt_ready: assert property ($rose(modeStateFlag) |-> statusPins.processorReady)
    else $error("virtual mode entered without processor ready");
  a_virt_stopped: assert property ($rose(modeStateFlag) |-> statusPins.startAccept == '0)
    else $error("virtual mode entered with an axis running");
  a_virt_clean: assert property ($rose(modeStateFlag) |-> !statusPins.encoderFault &&
    !statusPins.forcedStop && statusPins.servoError == '0)
    else $error("virtual mode entered with a fault present");
  a_real_stopped: assert property ($fell(modeStateFlag) |-> !ctrl_q[0] &&
    statusPins.startAccept == '0)
    else $error("real mode entered with an axis running");
  a_err_keeps_mode: assert property ($rose(modeSwitchErrorFlag) |-> $stable(modeStateFlag))
    else $error("mode changed on a failed switch");
  a_mode_after_req: assert property ($changed(modeStateFlag) |-> sinceWr_q <= 8'd60 &&
    ctrl_q[0] == modeStateFlag)
    else $error("mode changed without a matching request");
  a_err_sticky: assert property ($fell(modeSwitchErrorFlag) |->
    $past(wrAcc && paddr == OFS_STATUS && pwdata[1]))
    else $error("error flag cleared without a clearing write");
  a_cmd_passthru: assert property ($past(reset_n) && !compOn_q |->
    servoCmdOut == $past(servoCmdIn))
    else $error("servo command altered while compensation never enabled");
  c_enter: cover property ($rose(modeStateFlag));
  c_error: cover property ($rose(modeSwitchErrorFlag));
  c_exit: cover property ($fell(modeStateFlag));
  c_unmapped: cover property (pslverr);
endmodule
bind mmsc_mode_switch mmsc_mode_switch_sva #(.OP_CLKS(OP_CLKS)) u_sva (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .statusPins(statusPins), .commandSpeed(commandSpeed), .servoCmdIn(servoCmdIn),
  .servoCmdOut(servoCmdOut), .modeStateFlag(modeStateFlag),
  .modeSwitchErrorFlag(modeSwitchErrorFlag));
`default_nettype wire

/* File: test/mmsc_seq_model.sv */
// Purpose: Sequence program model that sets request and command flags over APB.
// Assumes: Zero or more wait states; the slave answers with pready.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module mmsc_seq_model (
  // Clock
  input  wire logic                        clock,
  // APB master side
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic [mmsc_pkg::ADDR_W-1:0]      paddr,
  output logic [31:0]                      pwdata,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  import mmsc_pkg::*;
  logic [31:0] dummy;
  logic        dummyErr;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, dummy, dummyErr);
  endtask
  // Leaving virtual mode with a residual offset would shift the cam phase.
  task automatic reqMode(input logic virt, input logic [5:0] rest);
    if (!virt) wr(OFS_PC_ADV, 32'h00000000);
    wr(OFS_CTRL, {26'h0, rest[5:1], virt});
  endtask
  task automatic compEnable(input logic [31:0] adv, input logic [31:0] tc);
    wr(OFS_PC_ADV, adv);
    wr(OFS_PC_TC, tc);
    wr(OFS_PC_CTRL, 32'h00000001);
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the mode switch checker.
// Assumes: Zero-wait APB slave; status pins synchronised in two cycles.
// Notes:   Axis five later becomes a cam axis so the output-module checks run.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mmsc_pkg::*;
  localparam int OPC = 8;
  logic              clock;
  logic              reset_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  mmsc_pins_t        pins;
  logic [31:0]       speed;
  logic [31:0]       cmdIn;
  logic [31:0]       cmdOut;
  logic              modeF;
  logic              errF;
  int                nMismatch;
  int                numChecks;
  mmsc_mode_switch #(.OP_CLKS(OPC)) dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .statusPins(pins), .commandSpeed(speed),
    .servoCmdIn(cmdIn), .servoCmdOut(cmdOut), .modeStateFlag(modeF),
    .modeSwitchErrorFlag(errF));
  mmsc_seq_model seq (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic conclude();
    if (nMismatch == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic        e;
    seq.xfer(1'b0, a, 32'h0, d, e);
    chk(what, exp, d);
  endtask
  task automatic waitIdle();
    logic [31:0] d;
    logic        e;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 100; i++) begin
      seq.xfer(1'b0, OFS_STATUS, 32'h0, d, e);
      if (d[SB_BUSY] === 1'b0) break;
      if (i == 99) chk("busyTimeout", 32'h0, 32'h1);
    end
  endtask
  function automatic mmsc_pins_t pinsWith(input int f, input int ax);
    mmsc_pins_t p;
    p = '0;
    p.processorReady = (f != 1);
    p.startAccept[ax] = (f == 2);
    p.encoderFault = (f == 3);
    p.forcedStop = (f == 4);
    p.servoResetBusy[ax] = (f == 5);
    p.servoError[ax] = (f == 6);
    p.homeReturnReq[ax] = (f == 7);
    return p;
  endfunction
  task automatic tryEnter(input logic [5:0] c, input int f, input int ax, input logic [7:0] code);
    @(posedge clock);
    pins <= pinsWith(f, ax);
    seq.reqMode(1'b1, c);
    waitIdle();
    chk("modeFlag", 32'h0, {31'h0, modeF});
    chk("errFlag", 32'h1, {31'h0, errF});
    rdChk(OFS_ERRINFO0, {24'h0, code}, "errCode");
    if (ax >= 5) rdChk(OFS_ERRINFO1, ax, "errAxis");
    @(posedge clock);
    pins <= pinsWith(0, 0);
    seq.wr(OFS_STATUS, 32'h00000002);
    seq.reqMode(1'b0, c);
    waitIdle();
    chk("errCleared", 32'h0, {31'h0, errF});
  endtask
  task automatic testResetAndHole();
    logic [31:0] d;
    logic        e;
    rdChk(OFS_STATUS, 32'h0, "statusReset");
    rdChk(OFS_ERRINFO0, 32'h0, "codeReset");
    seq.xfer(1'b0, 12'h030, 32'h0, d, e);
    chk("holeErr", 32'h1, {31'h0, e});
    chk("holeData", 32'h0, d);
  endtask
  task automatic testEnterExit();
    seq.reqMode(1'b1, 6'h1e);
    waitIdle();
    chk("modeVirtual", 32'h1, {31'h0, modeF});
    rdChk(OFS_STATUS, 32'h1, "statusVirtual");
    @(posedge clock);
    pins <= pinsWith(2, 2);
    seq.reqMode(1'b0, 6'h1e);
    waitIdle();
    chk("modeKept", 32'h1, {31'h0, modeF});
    chk("errExit", 32'h1, {31'h0, errF});
    rdChk(OFS_ERRINFO0, {24'h0, EC_VIRT_RUN}, "exitCode");
    rdChk(OFS_ERRINFO2, 32'h00000004, "exitAxes");
    @(posedge clock);
    pins <= pinsWith(0, 0);
    seq.wr(OFS_STATUS, 32'h00000002);
    seq.reqMode(1'b1, 6'h1e);
    waitIdle();
    seq.reqMode(1'b0, 6'h1e);
    waitIdle();
    chk("modeReal", 32'h0, {31'h0, modeF});
    chk("errReal", 32'h0, {31'h0, errF});
  endtask
  task automatic testComp();
    logic [31:0] d;
    logic        e;
    @(posedge clock);
    speed <= 32'h000f4240;
    seq.compEnable(32'h000000fa, 32'h00008000);
    repeat (OPC * 4) @(posedge clock);
    rdChk(OFS_MINOR, {16'h0, MINOR_TC}, "minorTc");
    rdChk(OFS_PC_MON, 32'h000000fa, "compAmount");
    chk("servoOut", 32'h000010fa, cmdOut);
    seq.wr(OFS_MINOR, 32'h0);
    rdChk(OFS_MINOR, 32'h0, "minorClr");
    seq.wr(OFS_PC_CTRL, 32'h0);
    seq.wr(OFS_PC_TC, 32'h00000004);
    repeat (OPC * 2) @(posedge clock);
    seq.wr(OFS_PC_CTRL, 32'h00000001);
    repeat (OPC) @(posedge clock);
    seq.xfer(1'b0, OFS_PC_MON, 32'h0, d, e);
    chk("smoothing", 32'h1, {31'h0, d > 32'h0 && d < 32'h000000fa});
    rdChk(OFS_MINOR, 32'h0, "minorValidTc");
  endtask
  initial begin
    #200000;
    nMismatch++;
    conclude();
  end
  initial begin
    nMismatch = 0;
    numChecks = 0;
    reset_n = 1'b0;
    pins = pinsWith(0, 0);
    speed = 32'h0;
    cmdIn = 32'h00001000;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    testResetAndHole();
    seq.wr(OFS_USED, 32'hffffffff);
    seq.wr(OFS_REALAX, 32'hffffffff);
    tryEnter(6'h1a, 0, 0, EC_READY);
    tryEnter(6'h1e, 1, 0, EC_READY);
    tryEnter(6'h1a, 4, 0, EC_READY);
    tryEnter(6'h1e, 2, 3, EC_MOVING);
    tryEnter(6'h16, 0, 0, EC_PROGRAM);
    tryEnter(6'h3e, 0, 0, EC_PROGRAM);
    tryEnter(6'h0e, 0, 0, EC_AXES);
    tryEnter(6'h1c, 0, 0, EC_SERVO_ON);
    tryEnter(6'h1e, 5, 7, EC_RST_BUSY);
    tryEnter(6'h1e, 3, 0, EC_ENCODER);
    tryEnter(6'h1e, 4, 0, EC_FSTOP);
    tryEnter(6'h1e, 6, 31, EC_SERVO_ERR);
    rdChk(OFS_ERRINFO2, 32'h1, "direction");
    seq.wr(OFS_REALAX, 32'hffffffdf);
    seq.wr(OFS_CAM, 32'h00000020);
    tryEnter(6'h1e, 7, 5, EC_HOME);
    tryEnter(6'h1e, 0, 5, EC_UNITS);
    seq.wr(OFS_UNITOK, 32'hffffffff);
    tryEnter(6'h1e, 0, 5, EC_CAM_DATA);
    seq.wr(OFS_CAMOK, 32'hffffffff);
    seq.wr(OFS_STROKE + 12'h014, 32'h80000000);
    tryEnter(6'h1e, 0, 5, EC_STROKE);
    seq.wr(OFS_STROKE + 12'h014, 32'h00000000);
    tryEnter(6'h1e, 0, 5, EC_STROKE);
    seq.wr(OFS_STROKE + 12'h014, 32'h7fffffff);
    tryEnter(6'h1e, 0, 5, EC_STROKE_LOC);
    seq.wr(OFS_LOCEVEN, 32'hffffffff);
    testEnterExit();
    testComp();
    conclude();
  end
endmodule
`default_nettype wire
